// File: tdl_dq_mem.sv
/*
  Storage of the deferred-trap queue: address and instruction word of each
  deferred-trap instruction, one write port, registered read port.
  Assumes the caller keeps the pointers and never writes a full queue.
*/
`include "tdl_regs.svh"

module tdl_dq_mem
(
  // clock
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_ce,
  // write
  input  wire logic                     i_wr,
  input  wire logic [`TDL_DQ_AW-1:0]    i_wr_addr,
  input  wire logic [63:0]              i_wr_data,
  // read
  input  wire logic [`TDL_DQ_AW-1:0]    i_rd_addr,
  output logic      [63:0]              o_rd_data
);

  logic [63:0] mem [`TDL_DQ_DEPTH];

  always_ff @(posedge i_ref_clk)
  begin
    if (i_ce)
    begin
      if (i_wr)
      begin
        mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

// File: tdl_far_model.sv
/*
  Far-side model: supervisor loading the trap table base, and an external
  interrupt requester that holds its level until the matching trap is taken.
  Assumes bench requests as one-cycle pulses driven at the falling edge.
*/
`include "tdl_regs.svh"

module tdl_far_model
(
  // clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rstn,
  // bench requests
  input  wire logic [3:0]            i_irq_req,
  input  wire logic                  i_tba_load,
  input  wire logic [`TDL_TBA_W-1:0] i_tba,
  // trap seen from the block
  input  wire logic                  i_trap_take,
  input  wire logic [`TDL_TT_W-1:0]  i_trap_type,
  // to the block
  output logic      [3:0]            o_irq_level,
  output logic                       o_tbr_wr,
  output logic      [`TDL_TBA_W-1:0] o_tbr_tba
);
  timeunit 1ns;
  timeprecision 1ps;

  // base bus shows junk while not writing
  always @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_irq_level <= 4'h0;
      o_tbr_wr    <= 1'b0;
      o_tbr_tba   <= 20'h0_0000;
    end
    else
    begin
      o_tbr_wr  <= i_tba_load;
      o_tbr_tba <= i_tba_load ? i_tba : ~o_tbr_tba;
      if (o_irq_level == 4'h0)
        o_irq_level <= i_irq_req;
      else if (i_trap_take && i_trap_type == {4'h1, o_irq_level})
        o_irq_level <= 4'h0;
    end
  end
endmodule

// File: tdl_pkg.sv
/*
  Types of the trap dispatch logic: dispatch states and trap categories.
  Assumes nothing beyond the constants header.
*/
package tdl_pkg;

  typedef enum logic [2:0]
  {
    TDL_IDLE     = 3'b001,
    TDL_SAVE_PC  = 3'b010,
    TDL_SAVE_NPC = 3'b100
  } tdl_state_t;

  typedef enum logic [1:0]
  {
    TDL_KIND_NONE         = 2'b00,
    TDL_KIND_PRECISE      = 2'b01,
    TDL_KIND_DEFERRED     = 2'b10,
    TDL_KIND_INTERRUPTING = 2'b11
  } tdl_kind_t;

endpackage

// File: tdl_regs.svh
/*
  Constants of the trap dispatch logic: trap vector layout, trap type codes,
  window save slots, reset values and deferred-trap queue sizing.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef TDL_REGS_SVH
`define TDL_REGS_SVH

// ----------------------------------------------------------------------------
// trap vector layout
// ----------------------------------------------------------------------------
`define TDL_TT_W          8
`define TDL_ENTRY_SHIFT   4
`define TDL_TBA_LSB       12
`define TDL_TBA_W         20
`define TDL_SW_HALF_BIT   7
`define TDL_TBR_RESET     20'h0_0000

// ----------------------------------------------------------------------------
// trap type codes
// ----------------------------------------------------------------------------
`define TDL_TT_IRQ_BASE   8'h10
`define TDL_TT_MCHK       8'h2b
`define TDL_TT_SW_BASE    8'h80

// ----------------------------------------------------------------------------
// register windows
// ----------------------------------------------------------------------------
`define TDL_CWP_W         3
`define TDL_CWP_RESET     3'h0
`define TDL_LOCAL_PC      3'h1
`define TDL_LOCAL_NPC     3'h2

// ----------------------------------------------------------------------------
// deferred-trap queue
// ----------------------------------------------------------------------------
`define TDL_DQ_AW         2
`define TDL_DQ_DEPTH      4
`define TDL_DQ_CNT_W      3

`endif

// File: tdl_trap_dispatch.sv
/*
  Trap selection and dispatch: picks the highest-priority pending exception
  or interrupt before each issue, vectors through the trap table, advances
  the window pointer, saves both program counters, keeps the deferred queue.
  Assumes pipeline request inputs are on i_ref_clk; the interrupt level is
  asynchronous.
*/
`include "tdl_regs.svh"

// How it works
// - every trap vectors into a table entry holding four handler instructions
// - software loads the table base; every vector uses that base
// - table offset comes from the taken trap's type number
// - upper half of table for software traps, lower half for hardware
// - trap decrements window pointer, writes pc and next pc into new window
// - other locals of the new window are left untouched for the handler
// - before each issue pick the single highest-priority pending event
// - precise trap is taken instead of issuing the offending instruction
// - deferred trap may come after later instructions changed state
// - keep a supervisor-readable queue of deferred-trap instructions
// - interrupting traps keep no emulation state
// - all traps precise except the listed categories
// - only floating-point and coprocessor traps are delivered deferred
// - non-resumable machine check delivered as interrupting
// - machine check on second access of two-access load/store interrupting
module tdl_trap_dispatch
(
  // clock, reset, enable
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rstn,
  input  wire logic                      i_ce,
  // trap table base
  input  wire logic                      i_tbr_wr,
  input  wire logic [`TDL_TBA_W-1:0]     i_tbr_tba,
  // issue
  input  wire logic                      i_issue_req,
  input  wire logic [31:0]               i_pc,
  input  wire logic [31:0]               i_npc,
  // precise hardware exception, software trap
  input  wire logic                      i_exc_valid,
  input  wire logic [6:0]                i_exc_type,
  input  wire logic                      i_swtrap_valid,
  input  wire logic [6:0]                i_swtrap_num,
  // floating-point or coprocessor exception
  input  wire logic                      i_fp_exc_valid,
  input  wire logic [6:0]                i_fp_exc_type,
  input  wire logic [31:0]               i_fp_exc_pc,
  input  wire logic [31:0]               i_fp_exc_instr,
  // machine check, interrupt
  input  wire logic                      i_mchk_valid,
  input  wire logic                      i_mchk_second,
  input  wire logic [3:0]                i_irq_level,
  // deferred queue supervisor side
  input  wire logic                      i_dq_pop,
  output logic                           o_dq_valid,
  output logic      [31:0]               o_dq_pc,
  output logic      [31:0]               o_dq_instr,
  output logic      [`TDL_DQ_CNT_W-1:0]  o_dq_count,
  output logic                           o_dq_full,
  // dispatch
  output logic                           o_issue_grant,
  output logic                           o_trap_take,
  output logic      [`TDL_TT_W-1:0]      o_trap_type,
  output tdl_pkg::tdl_kind_t             o_trap_kind,
  output logic      [31:0]               o_trap_target,
  output logic      [31:0]               o_tbr,
  output logic      [`TDL_CWP_W-1:0]     o_cwp,
  // window save port
  output logic                           o_win_wr,
  output logic      [`TDL_CWP_W-1:0]     o_win_cwp,
  output logic      [2:0]                o_win_local,
  output logic      [31:0]               o_win_data
);

  // --------------------------------------------------------------------------
  // interrupt level synchroniser
  // --------------------------------------------------------------------------
  logic [3:0] irq_meta;
  logic [3:0] irq_sync;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      irq_meta <= 4'h0;
      irq_sync <= 4'h0;
    end
    else if (i_ce)
    begin
      irq_meta <= i_irq_level;
      irq_sync <= irq_meta;
    end
  end

  // --------------------------------------------------------------------------
  // deferred-trap queue
  // --------------------------------------------------------------------------
  logic [`TDL_DQ_AW-1:0]    dq_wptr, next_dq_wptr;
  logic [`TDL_DQ_AW-1:0]    dq_rptr, next_dq_rptr;
  logic [`TDL_DQ_CNT_W-1:0] dq_count, next_dq_count;
  logic                     dq_head_taken, next_dq_head_taken;
  logic [6:0]               dq_type, next_dq_type;
  logic                     dq_push;
  logic                     dq_pop;
  logic                     take_deferred;
  logic [63:0]              dq_rd_data;

  always_comb
  begin
    dq_push            = i_fp_exc_valid && (dq_count != `TDL_DQ_CNT_W'(`TDL_DQ_DEPTH));
    dq_pop             = i_dq_pop && (dq_count != '0);
    next_dq_wptr       = dq_push ? dq_wptr + 1'b1 : dq_wptr;
    next_dq_rptr       = dq_pop ? dq_rptr + 1'b1 : dq_rptr;
    next_dq_count      = dq_count + `TDL_DQ_CNT_W'(dq_push) - `TDL_DQ_CNT_W'(dq_pop);
    next_dq_type       = (dq_push && dq_count == '0) ? i_fp_exc_type : dq_type;
    // set by the deferred trap wins over the pop that releases the head
    next_dq_head_taken = take_deferred ? 1'b1 : (dq_pop ? 1'b0 : dq_head_taken);
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      dq_wptr       <= '0;
      dq_rptr       <= '0;
      dq_count      <= '0;
      dq_head_taken <= 1'b0;
      dq_type       <= 7'h00;
      o_dq_valid    <= 1'b0;
      o_dq_count    <= '0;
      o_dq_full     <= 1'b0;
    end
    else if (i_ce)
    begin
      dq_wptr       <= next_dq_wptr;
      dq_rptr       <= next_dq_rptr;
      dq_count      <= next_dq_count;
      dq_head_taken <= next_dq_head_taken;
      dq_type       <= next_dq_type;
      o_dq_valid    <= (dq_count != '0);
      o_dq_count    <= next_dq_count;
      o_dq_full     <= (next_dq_count == `TDL_DQ_CNT_W'(`TDL_DQ_DEPTH));
    end
  end

  tdl_dq_mem u_dq_mem
  (
    .i_ref_clk (i_ref_clk),
    .i_ce      (i_ce),
    .i_wr      (dq_push),
    .i_wr_addr (dq_wptr),
    .i_wr_data ({i_fp_exc_pc, i_fp_exc_instr}),
    .i_rd_addr (dq_rptr),
    .o_rd_data (dq_rd_data)
  );

  assign o_dq_pc    = dq_rd_data[63:32];
  assign o_dq_instr = dq_rd_data[31:0];

  // --------------------------------------------------------------------------
  // priority selection
  // --------------------------------------------------------------------------
  logic               any_pending;
  logic [`TDL_TT_W-1:0] sel_type;
  tdl_pkg::tdl_kind_t sel_kind;
  tdl_pkg::tdl_state_t  state, next_state;

  always_comb
  begin
    any_pending   = 1'b1;
    take_deferred = 1'b0;
    sel_type      = '0;
    sel_kind      = tdl_pkg::TDL_KIND_NONE;
    if (i_mchk_valid)
    begin
      sel_type = `TDL_TT_MCHK;
      sel_kind = tdl_pkg::TDL_KIND_INTERRUPTING;
    end
    else if (i_exc_valid)
    begin
      sel_type = {1'b0, i_exc_type};
      sel_kind = tdl_pkg::TDL_KIND_PRECISE;
    end
    else if (i_swtrap_valid)
    begin
      sel_type = `TDL_TT_SW_BASE | {1'b0, i_swtrap_num};
      sel_kind = tdl_pkg::TDL_KIND_PRECISE;
    end
    else if (dq_count != '0 && !dq_head_taken)
    begin
      sel_type = {1'b0, dq_type};
      sel_kind = tdl_pkg::TDL_KIND_DEFERRED;
      take_deferred = (state == tdl_pkg::TDL_IDLE) && i_issue_req;
    end
    else if (irq_sync != 4'h0)
    begin
      sel_type = `TDL_TT_IRQ_BASE | {4'h0, irq_sync};
      sel_kind = tdl_pkg::TDL_KIND_INTERRUPTING;
    end
    else
    begin
      any_pending = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // dispatch state machine
  // --------------------------------------------------------------------------
  logic [`TDL_TBA_W-1:0] tba, next_tba;
  logic [`TDL_CWP_W-1:0] current_window_pointer, next_cwp;
  logic [31:0]           save_pc, next_save_pc;
  logic [31:0]           save_npc, next_save_npc;
  logic                  next_grant;
  logic                  next_take;
  logic [`TDL_TT_W-1:0]  next_type;
  tdl_pkg::tdl_kind_t    next_kind;
  logic [31:0]           next_target;
  logic                  next_win_wr;
  logic [2:0]            next_win_local;
  logic [31:0]           next_win_data;

  always_comb
  begin
    next_state     = state;
    next_tba       = i_tbr_wr ? i_tbr_tba : tba;
    next_cwp       = current_window_pointer;
    next_save_pc   = save_pc;
    next_save_npc  = save_npc;
    next_grant     = 1'b0;
    next_take      = 1'b0;
    next_type      = o_trap_type;
    next_kind      = o_trap_kind;
    next_target    = o_trap_target;
    next_win_wr    = 1'b0;
    next_win_local = o_win_local;
    next_win_data  = o_win_data;
    unique case (state)
      tdl_pkg::TDL_IDLE:
      begin
        if (i_issue_req && any_pending)
        begin
          next_take     = 1'b1;
          next_type     = sel_type;
          next_kind     = sel_kind;
          next_target   = {tba, sel_type, `TDL_ENTRY_SHIFT'(0)};
          next_cwp      = current_window_pointer - 1'b1;
          next_save_pc  = i_pc;
          next_save_npc = i_npc;
          next_state    = tdl_pkg::TDL_SAVE_PC;
        end
        else if (i_issue_req)
        begin
          next_grant = 1'b1;
        end
      end
      tdl_pkg::TDL_SAVE_PC:
      begin
        next_win_wr    = 1'b1;
        next_win_local = `TDL_LOCAL_PC;
        next_win_data  = save_pc;
        next_state     = tdl_pkg::TDL_SAVE_NPC;
      end
      tdl_pkg::TDL_SAVE_NPC:
      begin
        next_win_wr    = 1'b1;
        next_win_local = `TDL_LOCAL_NPC;
        next_win_data  = save_npc;
        next_state     = tdl_pkg::TDL_IDLE;
      end
      default:
      begin
        next_state = tdl_pkg::TDL_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state         <= tdl_pkg::TDL_IDLE;
      tba           <= `TDL_TBR_RESET;
      current_window_pointer           <= `TDL_CWP_RESET;
      save_pc       <= 32'h0000_0000;
      save_npc      <= 32'h0000_0000;
      o_issue_grant <= 1'b0;
      o_trap_take   <= 1'b0;
      o_trap_type   <= '0;
      o_trap_kind   <= tdl_pkg::TDL_KIND_NONE;
      o_trap_target <= 32'h0000_0000;
      o_win_wr      <= 1'b0;
      o_win_local   <= 3'h0;
      o_win_data    <= 32'h0000_0000;
    end
    else if (i_ce)
    begin
      state         <= next_state;
      tba           <= next_tba;
      current_window_pointer           <= next_cwp;
      save_pc       <= next_save_pc;
      save_npc      <= next_save_npc;
      o_issue_grant <= next_grant;
      o_trap_take   <= next_take;
      o_trap_type   <= next_type;
      o_trap_kind   <= next_kind;
      o_trap_target <= next_target;
      o_win_wr      <= next_win_wr;
      o_win_local   <= next_win_local;
      o_win_data    <= next_win_data;
    end
  end

  assign o_tbr     = {tba, `TDL_TBA_LSB'(0)};
  assign o_cwp     = current_window_pointer;
  assign o_win_cwp = current_window_pointer;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn || !i_ce);

  sequence s_save_pc;
    o_win_wr && o_win_local == `TDL_LOCAL_PC && o_win_cwp == o_cwp;
  endsequence

  sequence s_save_npc;
    o_win_wr && o_win_local == `TDL_LOCAL_NPC;
  endsequence

  AST_VEC_BASE: assert property (o_trap_take |-> o_trap_target[31:12] == o_tbr[31:12])
    else $error("trap target outside table base");
  AST_VEC_OFFSET: assert property (o_trap_take |->
    o_trap_target[11:4] == o_trap_type && o_trap_target[3:0] == 4'h0)
    else $error("trap target offset not type times sixteen");
  AST_SW_HALF: assert property (o_trap_take && o_trap_type[7] |-> $past(i_swtrap_valid))
    else $error("upper table half used without software trap");
  AST_CWP_ADV: assert property (o_trap_take |-> o_cwp == $past(o_cwp) - 3'h1)
    else $error("window pointer not advanced on trap");
  AST_SAVE_SEQ: assert property (o_trap_take |=> s_save_pc ##1 s_save_npc)
    else $error("program counters not saved after trap");
  AST_NO_ISSUE: assert property (o_trap_take |-> !o_issue_grant ##1 !o_issue_grant)
    else $error("instruction issued alongside trap");
  AST_MCHK_PRIO: assert property (o_trap_take && $past(i_mchk_valid) |->
    o_trap_type == `TDL_TT_MCHK && o_trap_kind == tdl_pkg::TDL_KIND_INTERRUPTING)
    else $error("machine check lost priority");
  AST_MCHK_SECOND: assert property (o_trap_take && $past(i_mchk_valid && i_mchk_second) |->
    o_trap_kind == tdl_pkg::TDL_KIND_INTERRUPTING)
    else $error("second-access machine check not interrupting");
  AST_DEFER_QUEUE: assert property (o_trap_take && o_trap_kind == tdl_pkg::TDL_KIND_DEFERRED |->
    $past(dq_count) != '0)
    else $error("deferred trap without queued instruction");
  AST_LOCALS: assert property (o_win_wr |->
    o_win_local == `TDL_LOCAL_PC || o_win_local == `TDL_LOCAL_NPC)
    else $error("window write beyond saved counters");

endmodule

// File: testbench.sv
/*
  Self-checking bench of the trap dispatch logic: precise, software,
  machine-check, interrupt and deferred traps, window saves, queue.
  Assumes the far-side model drives the table base and interrupt level.
*/
`include "tdl_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic trap; logic [7:0] tt; logic [1:0] kind; logic [31:0] pc; logic [31:0] following_program_counter; logic [2:0] current_window_pointer;} tdl_exp_t;

  logic clk = 0, rstn = 0, ce = 1, req = 0, exc_v = 0, sw_v = 0, fp_v = 0, mc_v = 0, mc_2 = 0, pop = 0, tba_load = 0;
  logic [31:0] pc = 0, following_program_counter = 0, fp_pc = 0, fp_in = 0;
  logic [6:0] exc_t = 0, sw_n = 0, fp_t = 0, t;
  logic [3:0] irq_req = 0, irq_lvl;
  logic [19:0] tba_val = 0, tba_x = 0, tba_bus;
  logic tbr_wr, dq_v, dq_full, grant, take, w_wr;
  logic [31:0] dq_pc, dq_in, target, trap_table_base_register, w_dat;
  logic [2:0] dq_cnt, current_window_pointer, w_cwp, w_loc, cwp_x = 0;
  logic [7:0] ttype, dtype;
  logic [1:0] step = 0;
  tdl_pkg::tdl_kind_t tkind;
  tdl_exp_t expq[$];
  tdl_exp_t cur;
  int fail_count = 0, samples_checked = 0, i;

  always #2 clk = ~clk;

  tdl_trap_dispatch i_tdl_trap_dispatch (.i_ref_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_tbr_wr(tbr_wr),
    .i_tbr_tba(tba_bus), .i_issue_req(req), .i_pc(pc), .i_npc(following_program_counter), .i_exc_valid(exc_v), .i_exc_type(exc_t),
    .i_swtrap_valid(sw_v), .i_swtrap_num(sw_n), .i_fp_exc_valid(fp_v), .i_fp_exc_type(fp_t), .i_fp_exc_pc(fp_pc),
    .i_fp_exc_instr(fp_in), .i_mchk_valid(mc_v), .i_mchk_second(mc_2), .i_irq_level(irq_lvl), .i_dq_pop(pop),
    .o_dq_valid(dq_v), .o_dq_pc(dq_pc), .o_dq_instr(dq_in), .o_dq_count(dq_cnt), .o_dq_full(dq_full),
    .o_issue_grant(grant), .o_trap_take(take), .o_trap_type(ttype), .o_trap_kind(tkind), .o_trap_target(target),
    .o_tbr(trap_table_base_register), .o_cwp(current_window_pointer), .o_win_wr(w_wr), .o_win_cwp(w_cwp), .o_win_local(w_loc), .o_win_data(w_dat));

  tdl_far_model i_tdl_far_model (.i_ref_clk(clk), .i_rstn(rstn), .i_irq_req(irq_req), .i_tba_load(tba_load),
    .i_tba(tba_val), .i_trap_take(take), .i_trap_type(ttype), .o_irq_level(irq_lvl), .o_tbr_wr(tbr_wr),
    .o_tbr_tba(tba_bus));

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // grant keeps req up for back-to-back issue; trap lets the save cycles pass
  task automatic issue(logic tr, logic [7:0] tt, logic [1:0] k);
    tdl_exp_t e;
    pc = $urandom() & 32'hffff_fffc;
    following_program_counter = pc + 32'h0000_0004;
    req = 1;
    if (tr)
      cwp_x = cwp_x - 3'h1;
    e = '{tr, tt, k, pc, following_program_counter, cwp_x};
    expq.push_back(e);
    @(negedge clk);
    if (tr)
    begin
      req = 0;
      repeat (2) @(negedge clk);
    end
  endtask

  task automatic done(string n);
    int k;
    req = 0;
    for (k = 0; k < 30 && (expq.size() != 0 || step != 0); k++)
      @(negedge clk);
    if (expq.size() != 0 || step != 0)
    begin
      fail_count++;
      report_and_stop();
    end
    $display("test %s done", n);
  endtask

  task automatic pop_one();
    pop = 1;
    @(negedge clk);
    pop = 0;
    repeat (2) @(negedge clk);
  endtask

  // --------------------------------------------------------------------------
  // answer monitor
  // --------------------------------------------------------------------------
  always @(negedge clk)
  begin
    if (rstn)
    begin
      if (grant === 1'b1 || take === 1'b1)
      begin
        if (expq.size() == 0)
          check("answer", 1, 0);
        else
        begin
          cur = expq.pop_front();
          check("take", take, cur.trap);
          check("grant", grant, !cur.trap);
          if (cur.trap)
          begin
            check("type", ttype, cur.tt);
            check("kind", tkind, cur.kind);
            check("target", target, {tba_x, cur.tt, 4'h0});
            check("cwp", current_window_pointer, cur.current_window_pointer);
            step = 1;
          end
        end
      end
      else if (step != 0)
      begin
        check("win_wr", w_wr, 1);
        check("win_cwp", w_cwp, cur.current_window_pointer);
        check("win_loc", w_loc, step);
        check("win_dat", w_dat, step == 1 ? cur.pc : cur.following_program_counter);
        step = step == 2 ? 2'd0 : 2'd2;
      end
      else
        check("win_idle", w_wr, 0);
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    void'($urandom(62034));
    repeat (8) @(negedge clk);
    check("rst_tbr", trap_table_base_register, 0);
    check("rst_cwp", current_window_pointer, 0);
    check("rst_cnt", dq_cnt, 0);
    rstn = 1;
    tba_x = 20'($urandom());
    tba_val = tba_x;
    tba_load = 1;
    @(negedge clk);
    tba_load = 0;
    repeat (2) @(negedge clk);
    check("tbr", trap_table_base_register, {tba_x, 12'h000});
    repeat (3) issue(0, 0, 0);
    done("base");
    @(negedge clk);
    ce = 0;
    req = 1;
    repeat (3) @(negedge clk);
    check("ce_hold", grant | take, 0);
    ce = 1;
    issue(0, 0, 0);
    done("enable");
    for (i = 0; i < 12; i++)
    begin
      t = (i % 6 == 0) ? 7'h00 : (i % 6 == 1) ? 7'h7f : 7'($urandom());
      exc_v = i < 6;
      sw_v = i >= 6;
      exc_t = t;
      sw_n = t;
      issue(1, {i >= 6, t}, 2'b01);
    end
    exc_v = 0;
    sw_v = 0;
    done("precise");
    irq_req = 4'h5;
    @(negedge clk);
    irq_req = 4'h0;
    repeat (4) @(negedge clk);
    mc_v = 1;
    exc_v = 1;
    sw_v = 1;
    exc_t = 7'h03;
    sw_n = 7'h09;
    for (i = 0; i < 2; i++)
    begin
      mc_2 = i[0];
      issue(1, `TDL_TT_MCHK, 2'b11);
    end
    mc_v = 0;
    issue(1, 8'h03, 2'b01);
    exc_v = 0;
    issue(1, 8'h89, 2'b01);
    sw_v = 0;
    issue(1, 8'h15, 2'b11);
    repeat (4) @(negedge clk);
    issue(0, 0, 0);
    done("priority");
    fp_t = 7'($urandom());
    dtype = {1'b0, fp_t};
    for (i = 0; i < 5; i++)
    begin
      fp_v = 1;
      fp_pc = 32'h0000_4000 + 32'(i * 4);
      fp_in = ~fp_pc;
      @(negedge clk);
      fp_t = ~fp_t;
    end
    fp_v = 0;
    repeat (2) @(negedge clk);
    check("dq_cnt", dq_cnt, 4);
    check("dq_full", dq_full, 1);
    check("dq_v", dq_v, 1);
    check("dq_pc", dq_pc, 32'h0000_4000);
    check("dq_in", dq_in, ~32'h0000_4000);
    issue(1, dtype, 2'b10);
    issue(0, 0, 0);
    done("defer_a");
    pop_one();
    check("dq_cnt", dq_cnt, 3);
    check("dq_pc", dq_pc, 32'h0000_4004);
    issue(1, dtype, 2'b10);
    done("defer_b");
    repeat (4) pop_one();
    check("dq_cnt", dq_cnt, 0);
    check("dq_v", dq_v, 0);
    check("dq_full", dq_full, 0);
    issue(0, 0, 0);
    done("drain");
    rstn = 0;
    cwp_x = 3'h0;
    tba_x = 20'h0_0000;
    repeat (2) @(negedge clk);
    check("rst2_cwp", current_window_pointer, 0);
    check("rst2_tbr", trap_table_base_register, 0);
    check("rst2_cnt", dq_cnt, 0);
    rstn = 1;
    exc_v = 1;
    exc_t = 7'h05;
    issue(1, 8'h05, 2'b01);
    exc_v = 0;
    done("reset");
    report_and_stop();
  end
endmodule
